// [pin_mux_pkg.sv]
// constants for the serial port pin multiplexer
package pin_mux_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NPINS = 6;
  localparam int unsigned CTRL_W = 11;
  localparam int unsigned LNK_W = 8;
  localparam int unsigned SYNC_STAGES = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_PORT_DIR = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PORT_FUNC = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PORT_DATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PORT_PIN = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_SER_CTRL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SER_STAT = 8'h14;

  // reset values
  localparam logic [NPINS-1:0] RST_PORT_DIR = 6'h00;
  localparam logic [NPINS-1:0] RST_PORT_FUNC = 6'h00;
  localparam logic [NPINS-1:0] RST_PORT_DATA = 6'h00;
  localparam logic [CTRL_W-1:0] RST_SER_CTRL = 11'h000;

  // pin positions
  localparam int unsigned PIN_CTRL_A = 0;
  localparam int unsigned PIN_CTRL_B = 1;
  localparam int unsigned PIN_FS = 2;
  localparam int unsigned PIN_BCLK = 3;
  localparam int unsigned PIN_RXD = 4;
  localparam int unsigned PIN_TXD = 5;

  // serial control fields
  localparam int unsigned CTL_SYNC_MODE = 0;
  localparam int unsigned CTL_A_FLAG = 1;
  localparam int unsigned CTL_B_FLAG = 2;
  localparam int unsigned CTL_FLAG0_OUT = 3;
  localparam int unsigned CTL_FLAG1_OUT = 4;
  localparam int unsigned CTL_FLAG0_VAL = 5;
  localparam int unsigned CTL_FLAG1_VAL = 6;
  localparam int unsigned CTL_FS_OUT = 7;
  localparam int unsigned CTL_BCLK_OUT = 8;
  localparam int unsigned CTL_RXFS_OUT = 9;
  localparam int unsigned CTL_RXCLK_OUT = 10;

  // serial status fields
  localparam int unsigned STA_FLAG0_IN = 0;
  localparam int unsigned STA_FLAG1_IN = 1;
  localparam int unsigned STA_TX_ACTIVE = 2;

  // link-side signal positions
  localparam int unsigned LNK_TXD = 0;
  localparam int unsigned LNK_TX_EN = 1;
  localparam int unsigned LNK_TX1 = 2;
  localparam int unsigned LNK_TX2 = 3;
  localparam int unsigned LNK_FS = 4;
  localparam int unsigned LNK_BCLK = 5;
  localparam int unsigned LNK_RXFS = 6;
  localparam int unsigned LNK_RXCLK = 7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [level_sync.sv]
// two-flop level synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule
`default_nettype wire

// [sync_serial_port_pin_mux.sv]
// pin multiplexer for the enhanced_sync_serial_port with gpio fallback
//
// Summary of operation
// - all six pins are gpio inputs after reset
// - gpio pin direction follows port_direction_reg bit
// - port_function_select_reg picks serial role per pin
// - async: control pin a is receive clock
// - sync: control pin a is tx1 or flag0
// - async: control pin b is receive frame sync
// - sync: control pin b is tx2 or flag1
// - frame sync shared in sync, tx only async
// - frame sync output internal, input from peer
// - bidirectional bit clock, shared only in sync
// - receive pin is input feeding receive shifter
// - transmit pin driven while transmitting
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_pin_mux
  import pin_mux_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic LINK_CLK_I,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [ADDR_W-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [DATA_W-1:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // pins
  input wire logic [NPINS-1:0] PIN_I,
  output logic [NPINS-1:0] PIN_O,
  output logic [NPINS-1:0] PIN_OE_N_O,
  // serial port side, link clock domain
  input wire logic SER_TXD_I,
  input wire logic SER_TX_EN_I,
  input wire logic SER_TX1_I,
  input wire logic SER_TX2_I,
  input wire logic SER_FS_I,
  input wire logic SER_BCLK_I,
  input wire logic SER_RXFS_I,
  input wire logic SER_RXCLK_I,
  // serial port side, system clock domain
  output logic SER_RXD_O,
  output logic SER_BCLK_IN_O,
  output logic SER_BCLK_RISE_O,
  output logic SER_BCLK_FALL_O,
  output logic SER_FS_IN_O,
  output logic SER_FS_RISE_O,
  output logic SER_RXCLK_IN_O,
  output logic SER_RXFS_IN_O
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
    addr_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction
  function automatic logic rise(input logic now, input logic prev);
    rise = now & ~prev;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [NPINS-1:0] dir_q, func_q, data_q, pin_s, pin_out_q, pin_oe_n_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [LNK_W-1:0] lnk_q, lnk_s;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [DATA_W-1:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic rxd_q, bclk_q, bclk_prev_q, bclk_rise_q, bclk_fall_q;
  logic fs_q, fs_prev_q, fs_rise_q, rxclk_q, rxfs_q;

  ////////////////////////////////////////////////////////////////////////////
  // link domain launch and crossing
  always_ff @(posedge LINK_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= {SER_RXCLK_I, SER_RXFS_I, SER_BCLK_I, SER_FS_I,
                SER_TX2_I, SER_TX1_I, SER_TX_EN_I, SER_TXD_I};
    end
  end
  level_sync #(.W(LNK_W)) u_lnk_sync (
    .clk_i(CLK_I),
    .rst_ni(NRST_I),
    .d_i(lnk_q),
    .q_o(lnk_s)
  );

  level_sync #(.W(NPINS)) u_pin_sync (
    .clk_i(CLK_I),
    .rst_ni(NRST_I),
    .d_i(PIN_I),
    .q_o(pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path
  wire aw_take = AWVALID_I & AWREADY_O;
  wire w_take = WVALID_I & WREADY_O;
  wire aw_have = aw_hold_q | aw_take;
  wire w_have = w_hold_q | w_take;
  wire wr_fire = aw_have & w_have & ~bvalid_q;
  wire [ADDR_W-1:0] wr_addr = aw_hold_q ? aw_addr_q : AWADDR_I;
  wire [DATA_W-1:0] wr_data = w_hold_q ? w_data_q : WDATA_I;
  wire [3:0] wr_strb = w_hold_q ? w_strb_q : WSTRB_I;
  wire wr_b0 = wr_fire & wr_strb[0];
  wire wr_b1 = wr_fire & wr_strb[1];
  wire hit_dir = addr_hit(wr_addr, OFF_PORT_DIR);
  wire hit_func = addr_hit(wr_addr, OFF_PORT_FUNC);
  wire hit_data = addr_hit(wr_addr, OFF_PORT_DATA);
  wire hit_ctrl = addr_hit(wr_addr, OFF_SER_CTRL);
  wire hit_ro = addr_hit(wr_addr, OFF_PORT_PIN) | addr_hit(wr_addr, OFF_SER_STAT);
  wire wr_ok = hit_dir | hit_func | hit_data | hit_ctrl | hit_ro;
  wire [CTRL_W-1:0] ctrl_d = {wr_b1 ? wr_data[CTRL_W-1:8] : ctrl_q[CTRL_W-1:8],
                              wr_b0 ? wr_data[7:0] : ctrl_q[7:0]};

  assign AWREADY_O = ~aw_hold_q & ~bvalid_q;
  assign WREADY_O = ~w_hold_q & ~bvalid_q;
  assign BVALID_O = bvalid_q;
  assign BRESP_O = bresp_q;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_hold_q <= 1'b1;
          aw_addr_q <= AWADDR_I;
        end
        if (w_take) begin
          w_hold_q <= 1'b1;
          w_data_q <= WDATA_I;
          w_strb_q <= WSTRB_I;
        end
        if (bvalid_q && BREADY_I) begin
          bvalid_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      dir_q <= RST_PORT_DIR;
      func_q <= RST_PORT_FUNC;
      data_q <= RST_PORT_DATA;
      ctrl_q <= RST_SER_CTRL;
    end else begin
      if (wr_b0 && hit_dir) begin
        dir_q <= wr_data[NPINS-1:0];
      end
      if (wr_b0 && hit_func) begin
        func_q <= wr_data[NPINS-1:0];
      end
      if (wr_b0 && hit_data) begin
        data_q <= wr_data[NPINS-1:0];
      end
      if (hit_ctrl) begin
        ctrl_q <= ctrl_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path
  wire sync_mode = ctrl_q[CTL_SYNC_MODE];
  wire a_flag = ctrl_q[CTL_A_FLAG];
  wire b_flag = ctrl_q[CTL_B_FLAG];
  wire flag0_in = pin_s[PIN_CTRL_A] & func_q[PIN_CTRL_A] & sync_mode & a_flag;
  wire flag1_in = pin_s[PIN_CTRL_B] & func_q[PIN_CTRL_B] & sync_mode & b_flag;
  wire [2:0] stat = {lnk_s[LNK_TX_EN], flag1_in, flag0_in};
  wire ar_take = ARVALID_I & ARREADY_O;
  wire rd_ok = addr_hit(ARADDR_I, OFF_PORT_DIR) | addr_hit(ARADDR_I, OFF_PORT_FUNC)
             | addr_hit(ARADDR_I, OFF_PORT_DATA) | addr_hit(ARADDR_I, OFF_PORT_PIN)
             | addr_hit(ARADDR_I, OFF_SER_CTRL) | addr_hit(ARADDR_I, OFF_SER_STAT);
  wire [DATA_W-1:0] rd_mux =
      addr_hit(ARADDR_I, OFF_PORT_DIR) ? {26'h0, dir_q} :
      addr_hit(ARADDR_I, OFF_PORT_FUNC) ? {26'h0, func_q} :
      addr_hit(ARADDR_I, OFF_PORT_DATA) ? {26'h0, data_q} :
      addr_hit(ARADDR_I, OFF_PORT_PIN) ? {26'h0, pin_s} :
      addr_hit(ARADDR_I, OFF_SER_CTRL) ? {21'h0, ctrl_q} :
      addr_hit(ARADDR_I, OFF_SER_STAT) ? {29'h0, stat} : 32'h0;

  assign ARREADY_O = ~rvalid_q;
  assign RVALID_O = rvalid_q;
  assign RRESP_O = rresp_q;
  assign RDATA_O = rdata_q;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= rd_mux;
    end else if (rvalid_q && RREADY_I) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin role selection
  wire [NPINS-1:0] ser_val, ser_drv;
  assign ser_val[PIN_CTRL_A] = sync_mode ? (a_flag ? ctrl_q[CTL_FLAG0_VAL] : lnk_s[LNK_TX1])
                                         : lnk_s[LNK_RXCLK];
  assign ser_drv[PIN_CTRL_A] = sync_mode ? (a_flag ? ctrl_q[CTL_FLAG0_OUT] : lnk_s[LNK_TX_EN])
                                         : ctrl_q[CTL_RXCLK_OUT];
  assign ser_val[PIN_CTRL_B] = sync_mode ? (b_flag ? ctrl_q[CTL_FLAG1_VAL] : lnk_s[LNK_TX2])
                                         : lnk_s[LNK_RXFS];
  assign ser_drv[PIN_CTRL_B] = sync_mode ? (b_flag ? ctrl_q[CTL_FLAG1_OUT] : lnk_s[LNK_TX_EN])
                                         : ctrl_q[CTL_RXFS_OUT];
  assign ser_val[PIN_FS] = lnk_s[LNK_FS];
  assign ser_drv[PIN_FS] = ctrl_q[CTL_FS_OUT];
  assign ser_val[PIN_BCLK] = lnk_s[LNK_BCLK];
  assign ser_drv[PIN_BCLK] = ctrl_q[CTL_BCLK_OUT];
  assign ser_val[PIN_RXD] = 1'b0;
  assign ser_drv[PIN_RXD] = 1'b0;
  assign ser_val[PIN_TXD] = lnk_s[LNK_TXD];
  assign ser_drv[PIN_TXD] = lnk_s[LNK_TX_EN];

  wire [NPINS-1:0] pin_out_d = (func_q & ser_val) | (~func_q & data_q);
  wire [NPINS-1:0] pin_oe_n_d = ~((func_q & ser_drv) | (~func_q & dir_q));

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pin_out_q <= '0;
      pin_oe_n_q <= '1;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

  assign PIN_O = pin_out_q;
  assign PIN_OE_N_O = pin_oe_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // inputs towards the serial port
  wire bclk_in = pin_s[PIN_BCLK] & func_q[PIN_BCLK] & ~ctrl_q[CTL_BCLK_OUT];
  wire fs_in = pin_s[PIN_FS] & func_q[PIN_FS] & ~ctrl_q[CTL_FS_OUT];
  wire rxclk_in = sync_mode ? bclk_in
                : pin_s[PIN_CTRL_A] & func_q[PIN_CTRL_A] & ~ctrl_q[CTL_RXCLK_OUT];
  wire rxfs_in = sync_mode ? fs_in
               : pin_s[PIN_CTRL_B] & func_q[PIN_CTRL_B] & ~ctrl_q[CTL_RXFS_OUT];

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rxd_q <= 1'b0;
      bclk_q <= 1'b0;
      bclk_prev_q <= 1'b0;
      bclk_rise_q <= 1'b0;
      bclk_fall_q <= 1'b0;
      fs_q <= 1'b0;
      fs_prev_q <= 1'b0;
      fs_rise_q <= 1'b0;
      rxclk_q <= 1'b0;
      rxfs_q <= 1'b0;
    end else begin
      rxd_q <= pin_s[PIN_RXD] & func_q[PIN_RXD];
      bclk_q <= bclk_in;
      bclk_prev_q <= bclk_q;
      bclk_rise_q <= rise(bclk_q, bclk_prev_q);
      bclk_fall_q <= rise(bclk_prev_q, bclk_q);
      fs_q <= fs_in;
      fs_prev_q <= fs_q;
      fs_rise_q <= rise(fs_q, fs_prev_q);
      rxclk_q <= rxclk_in;
      rxfs_q <= rxfs_in;
    end
  end

  assign SER_RXD_O = rxd_q;
  assign SER_BCLK_IN_O = bclk_q;
  assign SER_BCLK_RISE_O = bclk_rise_q;
  assign SER_BCLK_FALL_O = bclk_fall_q;
  assign SER_FS_IN_O = fs_q;
  assign SER_FS_RISE_O = fs_rise_q;
  assign SER_RXCLK_IN_O = rxclk_q;
  assign SER_RXFS_IN_O = rxfs_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!NRST_I);
  a_reset_gpio_input: assert property (
    ($past(func_q) == 6'h00 && $past(dir_q) == 6'h00) |-> PIN_OE_N_O == 6'h3f
  ) else $error("idle pins not left as inputs");
  a_gpio_dir_follow: assert property (
    ((~$past(func_q)) & (PIN_OE_N_O ^ ~$past(dir_q))) == 6'h00
  ) else $error("gpio drive differs from direction register");
  a_func_write_lands: assert property (
    (wr_fire && wr_strb[0] && hit_func) |=> func_q == $past(wr_data[5:0])
  ) else $error("function select write lost");
  a_ctrl_a_async: assert property (
    ($past(func_q[0]) && !$past(sync_mode))
      |-> PIN_OE_N_O[0] == !$past(ctrl_q[CTL_RXCLK_OUT])
  ) else $error("control pin a not acting as receive clock");
  a_ctrl_a_sync: assert property (
    ($past(func_q[0]) && $past(sync_mode) && !$past(a_flag))
      |-> PIN_O[0] == $past(lnk_s[LNK_TX1]) && PIN_OE_N_O[0] == !$past(lnk_s[LNK_TX_EN])
  ) else $error("control pin a not carrying tx1");
  a_ctrl_b_async: assert property (
    ($past(func_q[1]) && !$past(sync_mode))
      |-> PIN_OE_N_O[1] == !$past(ctrl_q[CTL_RXFS_OUT])
  ) else $error("control pin b not acting as receive frame sync");
  a_ctrl_b_flag: assert property (
    ($past(func_q[1]) && $past(sync_mode) && $past(b_flag))
      |-> PIN_O[1] == $past(ctrl_q[CTL_FLAG1_VAL])
  ) else $error("control pin b not carrying flag 1");
  a_rx_fs_select: assert property (
    (sync_mode && func_q[PIN_FS] && !ctrl_q[CTL_FS_OUT])[*2] |-> rxfs_q == $past(pin_s[PIN_FS])
  ) else $error("receiver frame sync not taken from shared pin");
  a_fs_drive: assert property (
    ($past(func_q[2]) && $past(ctrl_q[CTL_FS_OUT]))
      |-> !PIN_OE_N_O[2] && PIN_O[2] == $past(lnk_s[LNK_FS])
  ) else $error("frame sync output not driven");
  a_bclk_dir: assert property (
    $past(func_q[3]) |-> PIN_OE_N_O[3] == !$past(ctrl_q[CTL_BCLK_OUT])
  ) else $error("bit clock direction wrong");
  a_rx_pin_input: assert property (
    $past(func_q[4]) |-> PIN_OE_N_O[4]
  ) else $error("receive pin driven");
  a_tx_pin_drive: assert property (
    $past(func_q[5]) |-> PIN_OE_N_O[5] == !$past(lnk_s[LNK_TX_EN])
  ) else $error("transmit pin drive wrong");
  a_bclk_edge: assert property (
    SER_BCLK_RISE_O |-> $past(bclk_q) && !$past(bclk_q, 2) && !SER_BCLK_FALL_O
  ) else $error("bit clock rise pulse without edge");
  a_bresp_hold: assert property (
    (BVALID_O && !BREADY_I) |=> BVALID_O && $stable(BRESP_O)
  ) else $error("write response dropped");

endmodule
`default_nettype wire

// [serial_peer.sv]
// partner model: external serial peer on the six port pins
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [5:0] dev_o_i,
  input wire logic [5:0] dev_oe_n_i,
  input wire logic [5:0] drv_i,
  input wire logic [5:0] val_i,
  output logic [5:0] pin_o
);
  logic bclk_q = 1'b0;
  logic flt_q = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // bit clock, three system cycles per half, low between frames
  initial begin
    #1;
    forever begin
      #12;
      bclk_q = run_i ? ~bclk_q : 1'b0;
    end
  end
  // released lines wander
  always @(posedge clk_i) flt_q <= ~flt_q;
  ////////////////////////////////////////////////////////////////////////////////
  // wire resolution
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      if (dev_oe_n_i[k] == 1'b0) pin_o[k] = dev_o_i[k];
      else if (k == 3 && run_i) pin_o[k] = bclk_q;
      else if (drv_i[k]) pin_o[k] = val_i[k];
      else pin_o[k] = flt_q ^ k[0];
    end
  end
endmodule
`default_nettype wire

// [tb_sync_serial_port_pin_mux.sv]
// testbench for the serial port pin multiplexer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module tb_sync_serial_port_pin_mux;
  import pin_mux_pkg::*;
  logic clk = 0, nrst = 0, lclk = 0, run = 0;
  logic [7:0] awaddr = 0, araddr = 0, ser = 0;
  logic [31:0] wdata = 0, rdata, rdo;
  logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
  logic [5:0] pin_i, pin_o, oe_n, p_oe = 0, p_val = 0;
  logic [1:0] resp, bresp, rresp;
  logic rxd, bin, brise, bfall, fsin, fsrise, rxclk, rxfs, awr, wrr, arr, bv, rv;
  int n_errors = 0, n_compared = 0, n_rise = 0, n_fall = 0, n_fs = 0;
  always #2 clk = ~clk;
  always #7.5 lclk = ~lclk;
  ////////////////////////////////////////////////////////////////////////////////
  sync_serial_port_pin_mux u_dut (.CLK_I(clk), .NRST_I(nrst), .LINK_CLK_I(lclk),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awr), .WDATA_I(wdata),
    .WSTRB_I(4'hf), .WVALID_I(wvalid), .WREADY_O(wrr), .BRESP_O(bresp), .BVALID_O(bv),
    .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arr),
    .RDATA_O(rdo), .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(rready),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_N_O(oe_n),
    .SER_TXD_I(ser[LNK_TXD]), .SER_TX_EN_I(ser[LNK_TX_EN]), .SER_TX1_I(ser[LNK_TX1]),
    .SER_TX2_I(ser[LNK_TX2]), .SER_FS_I(ser[LNK_FS]), .SER_BCLK_I(ser[LNK_BCLK]),
    .SER_RXFS_I(ser[LNK_RXFS]), .SER_RXCLK_I(ser[LNK_RXCLK]), .SER_RXD_O(rxd),
    .SER_BCLK_IN_O(bin), .SER_BCLK_RISE_O(brise), .SER_BCLK_FALL_O(bfall),
    .SER_FS_IN_O(fsin), .SER_FS_RISE_O(fsrise), .SER_RXCLK_IN_O(rxclk),
    .SER_RXFS_IN_O(rxfs));
  serial_peer u_peer (.clk_i(clk), .run_i(run), .dev_o_i(pin_o), .dev_oe_n_i(oe_n),
    .drv_i(p_oe), .val_i(p_val), .pin_o(pin_i));
  always @(posedge clk) begin
    if (brise === 1'b1) n_rise++;
    if (bfall === 1'b1) n_fall++;
    if (fsrise === 1'b1) n_fs++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] sb(int p);
    return 8'(1 << p);
  endfunction
  task automatic end_of_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit ad, wd;
    ad = 0;
    wd = 0;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    forever begin
      @(posedge clk);
      if (bv === 1'b1) begin
        resp = bresp;
        break;
      end
      if (!ad && awr === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wrr === 1'b1) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    `CHK(ad & wd, 1'b1)
  endtask
  task automatic axr(input logic [7:0] a);
    bit ad;
    ad = 0;
    arvalid <= 1'b1;
    araddr <= a;
    forever begin
      @(posedge clk);
      if (rv === 1'b1) begin
        rdata = rdo;
        resp = rresp;
        break;
      end
      if (!ad && arr === 1'b1) begin
        ad = 1;
        arvalid <= 1'b0;
      end
    end
    `CHK(ad, 1'b1)
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] d);
    axw(a, d);
    `CHK(resp, RESP_OKAY)
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    `CHK(rdata, e)
    `CHK(resp, RESP_OKAY)
  endtask
  task automatic settle();
    repeat (12) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end
  initial begin
    int r0, f0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHK(oe_n, 6'h3f)
    `CHK(pin_o, 6'h00)
    rchk(OFF_PORT_DIR, 32'h0);
    rchk(OFF_PORT_FUNC, 32'h0);
    rchk(OFF_SER_CTRL, 32'h0);
    // gpio direction and levels
    p_oe <= 6'h30;
    p_val <= 6'h10;
    wchk(OFF_PORT_DIR, 32'h0f);
    wchk(OFF_PORT_DATA, 32'h05);
    settle();
    `CHK(oe_n, 6'h30)
    `CHK(pin_o[3:0], 4'h5)
    rchk(OFF_PORT_PIN, 32'h15);
    // unmapped place
    axw(8'h40, 32'h3f);
    `CHK(resp, RESP_SLVERR)
    axr(8'h40);
    `CHK(resp, RESP_SLVERR)
    `CHK(rdata, 32'h0)
    rchk(OFF_PORT_DIR, 32'h0f);
    // transmit pin next to a gpio output
    p_oe <= 6'h00;
    ser <= sb(LNK_TX_EN) | sb(LNK_TXD);
    wchk(OFF_PORT_DIR, 32'h01);
    wchk(OFF_PORT_DATA, 32'h01);
    wchk(OFF_PORT_FUNC, 32'h20);
    settle();
    `CHK(oe_n, 6'h1e)
    `CHK(pin_o[5], 1'b1)
    `CHK(pin_o[0], 1'b1)
    axr(OFF_SER_STAT);
    `CHK(rdata[STA_TX_ACTIVE], 1'b1)
    ser <= sb(LNK_TX_EN);
    settle();
    `CHK(pin_o[5], 1'b0)
    ser <= 8'h00;
    settle();
    `CHK(oe_n[5], 1'b1)
    // receive pin never driven
    wchk(OFF_PORT_DIR, 32'h10);
    wchk(OFF_PORT_FUNC, 32'h10);
    p_oe <= 6'h10;
    for (int v = 0; v < 2; v++) begin
      p_val <= 6'(v << 4);
      settle();
      `CHK(oe_n[4], 1'b1)
      `CHK(rxd, v[0])
    end
    // sync control pins: flag out, transmitter out, flag in
    p_oe <= 6'h00;
    wchk(OFF_PORT_DIR, 32'h00);
    wchk(OFF_PORT_FUNC, 32'h03);
    for (int k = 0; k < 2; k++) begin
      wchk(OFF_SER_CTRL, 32'h1 | (32'h2 << k) | (32'h8 << k) | (32'h20 << k));
      settle();
      `CHK(oe_n[k], 1'b0)
      `CHK(pin_o[k], 1'b1)
      ser <= sb(LNK_TX_EN) | sb(LNK_TX1) | sb(LNK_TX2);
      wchk(OFF_SER_CTRL, 32'h1);
      settle();
      `CHK(pin_o[k], 1'b1)
      ser <= sb(LNK_TX_EN);
      settle();
      `CHK(pin_o[k], 1'b0)
      ser <= 8'h00;
      wchk(OFF_SER_CTRL, 32'h1 | (32'h2 << k));
      settle();
      p_oe <= 6'h03;
      p_val <= 6'h03;
      settle();
      axr(OFF_SER_STAT);
      `CHK(rdata[k], 1'b1)
      p_oe <= 6'h00;
    end
    // async receive clock and frame sync on the control pins
    ser <= sb(LNK_RXCLK) | sb(LNK_RXFS);
    wchk(OFF_SER_CTRL, 32'h600);
    settle();
    `CHK(oe_n[1:0], 2'b00)
    `CHK(pin_o[1:0], 2'b11)
    ser <= 8'h00;
    wchk(OFF_SER_CTRL, 32'h0);
    p_oe <= 6'h03;
    for (int v = 1; v < 3; v++) begin
      p_val <= 6'(v);
      settle();
      `CHK(rxclk, v[0])
      `CHK(rxfs, v[1])
    end
    // frame sync pin, input in both modes, then output
    p_oe <= 6'h06;
    p_val <= 6'h00;
    settle();
    wchk(OFF_PORT_FUNC, 32'h06);
    wchk(OFF_SER_CTRL, 32'h1);
    settle();
    p_val <= 6'h04;
    settle();
    `CHK(fsin, 1'b1)
    `CHK(rxfs, 1'b1)
    `CHK(n_fs, 1)
    wchk(OFF_SER_CTRL, 32'h0);
    settle();
    `CHK(fsin, 1'b1)
    `CHK(rxfs, 1'b0)
    p_oe <= 6'h00;
    ser <= sb(LNK_FS);
    wchk(OFF_SER_CTRL, 32'h80);
    settle();
    `CHK(oe_n[2], 1'b0)
    `CHK(pin_o[2], 1'b1)
    `CHK(fsin, 1'b0)
    // external bit clock at the slowest allowed sampling margin
    ser <= 8'h00;
    p_oe <= 6'h08;
    p_val <= 6'h00;
    wchk(OFF_PORT_FUNC, 32'h08);
    wchk(OFF_SER_CTRL, 32'h1);
    settle();
    r0 = n_rise;
    f0 = n_fall;
    run <= 1'b1;
    repeat (30) @(posedge clk);
    run <= 1'b0;
    settle();
    `CHK(n_rise - r0, 5)
    `CHK(n_fall - f0, 5)
    p_oe <= 6'h00;
    ser <= sb(LNK_BCLK);
    wchk(OFF_SER_CTRL, 32'h101);
    settle();
    `CHK(oe_n[3], 1'b0)
    `CHK(pin_o[3], 1'b1)
    `CHK(bin, 1'b0)
    end_of_test();
  end
endmodule
`undef CHK
`default_nettype wire
